// [nsg_pr_lfsr.sv]
// package of shared constants and types, plus the nine-stage ranging code register.
// assumes one 50 MHz clock with a synchronous active-high reset; steps come from the caller.
package nsg_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned EPOCH_US        = 1000;
    localparam int unsigned CHIP_RATE_BPS   = 511_000;
    localparam int unsigned DATA_RATE_BPS   = 50;
    localparam int unsigned MEANDER_HZ      = 100;
    localparam int unsigned DATA_BIT_MS     = 20;
    localparam int unsigned MEANDER_BIT_MS  = 1000 / MEANDER_HZ;
    localparam int unsigned EPOCH_CYC_DFLT  = CLK_HZ / 1_000_000 * EPOCH_US;
    localparam int unsigned CHIPS_PER_EPOCH = CHIP_RATE_BPS / 1000 * EPOCH_US / 1000;
    localparam int unsigned DATA_EPOCHS     = 1000 / DATA_RATE_BPS;
    localparam int unsigned MEANDER_EPOCHS  = MEANDER_BIT_MS * 1000 / EPOCH_US;
    localparam int unsigned CNT_W           = 5;

    localparam int unsigned PRR_STAGES      = 9;
    localparam int unsigned PRR_TAP_LO      = 5;
    localparam int unsigned PRR_TAP_HI      = 9;
    localparam int unsigned PRR_OUT_STAGE   = 7;
    localparam logic [8:0]  PRR_INIT        = 9'h1ff;

    localparam int          CHAN_W          = 5;
    localparam logic signed [CHAN_W-1:0] CHAN_MIN = -5'sd7;
    localparam logic signed [CHAN_W-1:0] CHAN_MAX = 5'sd13;

    typedef logic signed [CHAN_W-1:0] nsg_chan_t;

    typedef struct packed {
        logic data_bit;
        logic almanac;
    } nsg_msg_t;

    typedef struct packed {
        logic upper_carrier_band;
        logic lower_carrier_band;
    } nsg_mod_t;
endpackage : nsg_pkg

`timescale 1ns/1ps
module nsg_pr_lfsr (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic load_in,
    input  wire logic step_in,
    output logic      chip_out
);
    import nsg_pkg::*;

    // stage n of the register is bit n-1
    logic [PRR_STAGES-1:0] stages;

    always_ff @(posedge clock_in) begin
        if (rst_in || load_in) begin
            stages <= PRR_INIT;
        end else if (step_in) begin
            stages <= {stages[PRR_STAGES-2:0],
                       stages[PRR_TAP_LO-1] ^ stages[PRR_TAP_HI-1]};
        end
    end

    assign chip_out = stages[PRR_OUT_STAGE-1];
endmodule : nsg_pr_lfsr

// [nsg_modulator.sv]
// top of the modulating sequence generator: ranging code, data and meander combined.
// assumes the message source sits on the same clock and holds msg_in until msg_take_out.
// How it works
// - upper band is code, data, meander xor
// - lower band is code xor meander only
// - maximal-length code, 511 kbit/s, 1 ms period
// - data bits sent at 50 bit/s
// - all timing from one common clock
// - message carries immediate and almanac classes
// - almanac channel number valid -7 to 13
// - nine stages, all-ones load, seventh stage out
// - feedback polynomial 1 + x^5 + x^9
// - 100 Hz auxiliary meander is third component
// - data in relative code, 20 ms bits
`timescale 1ns/1ps
module nsg_modulator #(
    parameter int unsigned EPOCH_CYCLES = nsg_pkg::EPOCH_CYC_DFLT
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire nsg_pkg::nsg_msg_t msg_in,
    input  wire logic              msg_valid_in,
    input  wire nsg_pkg::nsg_chan_t chan_in,
    output nsg_pkg::nsg_mod_t      mod_out,
    output logic                   epoch_out,
    output logic                   msg_take_out,
    output logic                   almanac_out,
    output logic                   chan_valid_out
);
    import nsg_pkg::*;

    localparam int unsigned CW = $clog2(EPOCH_CYCLES);
    localparam int unsigned AW = $clog2(EPOCH_CYCLES + CHIPS_PER_EPOCH) + 1;
    localparam logic [CW-1:0]    EPOCH_LAST   = CW'(EPOCH_CYCLES - 1);
    localparam logic [AW-1:0]    ACC_INC      = AW'(CHIPS_PER_EPOCH);
    localparam logic [AW-1:0]    ACC_WRAP     = AW'(EPOCH_CYCLES);
    localparam logic [CNT_W-1:0] DATA_LAST    = CNT_W'(DATA_EPOCHS - 1);
    localparam logic [CNT_W-1:0] MEANDER_LAST = CNT_W'(MEANDER_EPOCHS - 1);

    logic [CW-1:0]    cyc_cnt;
    logic [AW-1:0]    acc;
    logic [AW-1:0]    next_acc;
    logic [CNT_W-1:0] data_cnt;
    logic [CNT_W-1:0] meander_cnt;
    logic             epoch;
    logic             chip_step;
    logic             chip;
    logic             meander;
    logic             tx_bit;

    // one epoch is exactly one code period; the meander and data counters below count epochs of this clock
    assign epoch = (cyc_cnt == EPOCH_LAST);

    always_ff @(posedge clock_in) begin
        if (rst_in || epoch) begin
            cyc_cnt <= '0;
        end else begin
            cyc_cnt <= cyc_cnt + CW'(1);
        end
    end

    // fractional divider: the clock is no integer multiple of the chip rate, so a
    // phase accumulator spreads exactly the code length of steps over each epoch
    assign next_acc  = acc + ACC_INC;
    assign chip_step = (next_acc >= ACC_WRAP);

    always_ff @(posedge clock_in) begin
        if (rst_in || epoch) begin
            acc <= '0;
        end else if (chip_step) begin
            acc <= next_acc - ACC_WRAP;
        end else begin
            acc <= next_acc;
        end
    end

    // the last step of an epoch coincides with the reload, which wins
    nsg_pr_lfsr u_prr (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .load_in  (epoch),
        .step_in  (chip_step),
        .chip_out (chip)
    );

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meander_cnt <= '0;
            meander     <= 1'b0;
        end else if (epoch) begin
            if (meander_cnt == MEANDER_LAST) begin
                meander_cnt <= '0;
                meander     <= ~meander;
            end else begin
                meander_cnt <= meander_cnt + CNT_W'(1);
            end
        end
    end

    // an absent message bit is sent as zero, which leaves the relative code unchanged
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            data_cnt     <= '0;
            tx_bit       <= 1'b0;
            almanac_out  <= 1'b0;
            msg_take_out <= 1'b0;
        end else begin
            msg_take_out <= 1'b0;
            if (epoch) begin
                if (data_cnt == DATA_LAST) begin
                    data_cnt     <= '0;
                    tx_bit       <= tx_bit ^ (msg_valid_in & msg_in.data_bit);
                    almanac_out  <= msg_valid_in & msg_in.almanac;
                    msg_take_out <= msg_valid_in;
                end else begin
                    data_cnt <= data_cnt + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            chan_valid_out <= 1'b0;
        end else begin
            chan_valid_out <= (chan_in >= CHAN_MIN) && (chan_in <= CHAN_MAX);
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mod_out   <= '0;
            epoch_out <= 1'b0;
        end else begin
            mod_out.upper_carrier_band <= chip ^ tx_bit ^ meander;
            mod_out.lower_carrier_band <= chip ^ meander;
            epoch_out                  <= epoch;
        end
    end
endmodule : nsg_modulator

// [nsg_modulator_properties.sv]
// port checker for the modulating sequence generator.
// assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module nsg_modulator_properties #(
    parameter int unsigned EPOCH_CYCLES = 1022
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire nsg_pkg::nsg_msg_t msg_in,
    input wire logic msg_valid_in,
    input wire nsg_pkg::nsg_chan_t chan_in,
    input wire nsg_pkg::nsg_mod_t mod_out,
    input wire logic epoch_out,
    input wire logic msg_take_out,
    input wire logic almanac_out,
    input wire logic chan_valid_out
);
    import nsg_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [15:0] cnt;
    wire x = mod_out.upper_carrier_band ^ mod_out.lower_carrier_band;
    always_ff @(posedge clock_in) begin
        cnt <= rst_in ? 16'h0 : (epoch_out ? 16'h1 : cnt + 16'h1);
    end
    a_epoch_period: assert property (epoch_out == (cnt == EPOCH_CYCLES))
        else $error("epoch spacing wrong");
    a_take_epoch: assert property (msg_take_out |-> epoch_out && $past(msg_valid_in))
        else $error("take off boundary");
    a_data_hold: assert property ($changed(x) |-> $past(msg_take_out))
        else $error("data moved off boundary");
    a_diff_code: assert property ($past(msg_take_out) |-> x == ($past(x) ^ $past(msg_in.data_bit, 2)))
        else $error("relative code wrong");
    a_alm_change: assert property ($changed(almanac_out) |-> epoch_out)
        else $error("class moved off boundary");
    a_reset_zero: assert property (disable iff (1'b0) rst_in |=> !mod_out && !epoch_out && !msg_take_out) // RESET
        else $error("outputs not cleared");
    a_first_chip: assert property ($fell(rst_in) |=> mod_out == 2'b11)
        else $error("first chip wrong");
    a_chan_range: assert property (!rst_in |=> chan_valid_out == ($past(chan_in) >= CHAN_MIN && $past(chan_in) <= CHAN_MAX))
        else $error("channel check wrong");
endmodule : nsg_modulator_properties
bind nsg_modulator nsg_modulator_properties #(.EPOCH_CYCLES(EPOCH_CYCLES)) chk_u (
    .clock_in(clock_in), .rst_in(rst_in), .msg_in(msg_in), .msg_valid_in(msg_valid_in),
    .chan_in(chan_in), .mod_out(mod_out), .epoch_out(epoch_out), .msg_take_out(msg_take_out),
    .almanac_out(almanac_out), .chan_valid_out(chan_valid_out));

// [nsg_rx_model.sv]
// receiver model: recovers the data train from both bands.
// assumes bands sampled on the transmitter clock.
`timescale 1ns/1ps
module nsg_rx_model (
    input  wire nsg_pkg::nsg_mod_t mod_in,
    output logic                   bit_out
);
    import nsg_pkg::*;
    // shared code and meander cancel out
    assign bit_out = mod_in.upper_carrier_band ^ mod_in.lower_carrier_band;
endmodule : nsg_rx_model

// [test_nsg_modulator.sv]
// testbench for the modulating sequence generator.
// assumes a short epoch so three data bits fit in one run.
`timescale 1ns/1ps
module test_nsg_modulator;
    import nsg_pkg::*;
    localparam int unsigned EC = 1022;
    logic clock_in = 0, rst_in = 1, msg_valid_in = 0, rx_bit;
    logic epoch_out, msg_take_out, almanac_out, chan_valid_out;
    nsg_msg_t msg_in = '0;
    nsg_chan_t chan_in = '0;
    nsg_mod_t mod_out;
    logic code_seen [EC];
    int fails = 0, check_count = 0, ep = 0;
    nsg_modulator #(.EPOCH_CYCLES(EC)) dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .msg_in(msg_in), .msg_valid_in(msg_valid_in), .chan_in(chan_in), .mod_out(mod_out),
        .epoch_out(epoch_out), .msg_take_out(msg_take_out), .almanac_out(almanac_out),
        .chan_valid_out(chan_valid_out));
    nsg_rx_model rx_u (.mod_in(mod_out), .bit_out(rx_bit));
    initial forever #10 clock_in = ~clock_in;
    always @(posedge clock_in) ep <= rst_in ? 0 : ep + int'(epoch_out);
    task chk(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask : chk
    task stop_test;
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task run_chan;
        nsg_chan_t v[4] = '{-5'sd8, -5'sd7, 5'sd13, 5'sd14};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in) chan_in <= v[i];
            @(posedge clock_in) #1 chk("chan_valid", i == 1 || i == 2, chan_valid_out);
        end
    endtask : run_chan
    // the reload and the divider restart each epoch, so the lower band must repeat exactly
    // every epoch while the meander stays put; a stuck code would also repeat, hence the mix
    task run_code;
        int diffs;
        int ones;
        diffs = 0;
        ones = 0;
        while (!epoch_out) @(posedge clock_in) #1;
        for (int n = 0; n < EC; n++) begin
            code_seen[n] = mod_out.lower_carrier_band;
            ones += int'(mod_out.lower_carrier_band);
            @(posedge clock_in) #1;
        end
        for (int n = 0; n < EC; n++) begin
            diffs += int'(mod_out.lower_carrier_band !== code_seen[n]);
            @(posedge clock_in) #1;
        end
        chk("code_repeat", 1'b1, diffs == 0);
        chk("code_mixed", 1'b1, ones > 0 && ones < int'(EC));
    endtask : run_code
    // waits for the next 20-epoch boundary; a refused bit must leave the train alone
    task send_bit(input logic vld, input logic d, input logic alm);
        logic prev;
        prev = rx_bit;
        @(posedge clock_in) begin
            msg_valid_in <= vld;
            msg_in <= '{data_bit: d, almanac: alm};
        end
        for (int n = 0; n < 25 * EC && !(epoch_out && ep % 20 == 19); n++) @(posedge clock_in) #1;
        chk("take", vld, msg_take_out);
        chk("almanac", vld & alm, almanac_out);
        @(posedge clock_in) msg_valid_in <= 1'b0;
        #1 chk("data", prev ^ (vld & d), rx_bit);
        chk("reload", 1'b1, mod_out.lower_carrier_band);
    endtask : send_bit
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        run_chan;
        run_code;
        send_bit(1'b1, 1'b1, 1'b1);
        send_bit(1'b0, 1'b1, 1'b1);
        send_bit(1'b1, 1'b0, 1'b0);
        stop_test;
    end
    initial begin
        repeat (70000) @(posedge clock_in);
        fails++;
        stop_test;
    end
endmodule : test_nsg_modulator
